// *** design/sscm_pkg.sv ***
// package of constants and types for the serial clock management block
package sscm_pkg;

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  localparam int          SSCM_DIV_W      = 12;
  localparam logic [11:0] SSCM_DIV_RST    = 12'h000;
  localparam logic [11:0] SSCM_DIV_MAX    = 12'hfff;
  localparam int          SSCM_DIV_FACTOR_MAX = 8190;

  // ---------------------------------------------------------------
  // clock source select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SSCM_CKS_DIV   = 2'h0;
  localparam logic [1:0] SSCM_CKS_OTHER = 2'h1;
  localparam logic [1:0] SSCM_CKS_PIN   = 2'h2;

  // ---------------------------------------------------------------
  // clock pin output mode codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SSCM_CKO_NONE  = 2'h0;
  localparam logic [1:0] SSCM_CKO_CONT  = 2'h1;
  localparam logic [1:0] SSCM_CKO_XFER  = 2'h2;

  // ---------------------------------------------------------------
  // start selection codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SSCM_START_AUTO  = 3'h0;
  localparam logic [2:0] SSCM_START_OTHER = 3'h1;
  localparam logic [2:0] SSCM_START_LOW   = 3'h2;
  localparam logic [2:0] SSCM_START_HIGH  = 3'h3;
  localparam logic [2:0] SSCM_START_FALL  = 3'h4;
  localparam logic [2:0] SSCM_START_RISE  = 3'h5;
  localparam logic [2:0] SSCM_START_LEVEL = 3'h6;
  localparam logic [2:0] SSCM_START_EDGE  = 3'h7;

  // ---------------------------------------------------------------
  // side state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SSCM_IDLE,
    SSCM_WAIT,
    SSCM_XFER
  } sscm_state_e;

  localparam int SSCM_IRQ_W = 4;

endpackage

// *** design/sscm_divider.sv ***
// master clock divider giving a 50% duty divided clock and its edge pulses
`timescale 1ns/1ps
module sscm_divider
  import sscm_pkg::*;
#(
  parameter int DIV_W = SSCM_DIV_W
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // setting
  input  wire logic [DIV_W-1:0] div_value,
  // divided clock
  output logic                  div_clk,
  output logic                  div_rise,
  output logic                  div_fall
);

  initial begin
    if (DIV_W < 1 || DIV_W > 16) $error("sscm_divider: DIV_W out of range");
  end

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] last_div_reg;
  logic             phase_reg;
  logic             wrap;
  logic             changed;

  assign changed = (div_value != last_div_reg);
  assign wrap    = (div_value != '0) && !changed &&
                   (cnt_reg == div_value - DIV_W'(1));

  // ---------------------------------------------------------------
  // half period counter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_reg      <= '0;
      last_div_reg <= '0;
    end else begin
      last_div_reg <= div_value;
      if (changed || div_value == '0 || wrap) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + DIV_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // output phase
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase_reg <= 1'b0;
    end else if (div_value == '0 || changed) begin
      phase_reg <= 1'b0;
    end else if (wrap) begin
      phase_reg <= ~phase_reg;
    end
  end

  assign div_clk  = phase_reg;
  assign div_rise = wrap && !phase_reg;
  assign div_fall = wrap && phase_reg;

endmodule

// *** design/sscm_top.sv ***
// clock management for a synchronous serial controller with tx and rx sides
//
// Behaviour
// - divider value is 12 bits, up to 4095, dividing master clock up to 8190
// - divider value zero leaves the divider inactive with no divided clock
// - each divided clock phase lasts divider value master clock periods
// - the one divided clock feeds both receiver and transmitter
// - tx bit clock selected from tx pin, rx clock or divided clock
// - rx bit clock selected from rx pin, tx clock or divided clock
// - tx may invert its internal bit clock independently
// - rx may invert its internal bit clock independently
// - inversion affects internal clock only, never the driven clock pin
// - tx drives its clock pin continuously or only during transfers
// - rx drives its clock pin continuously or only during transfers
// - a side can run from the other clock and start with it
// - interrupt asserted while any source is pending and enabled
// - status shows every pending source, whether enabled or not
// - each side has data, clock and frame sync; clock and sync two-way
// - transfers start automatically or on frame sync events
`timescale 1ns/1ps
module sscm_top
  import sscm_pkg::*;
#(
  parameter int DIV_W = SSCM_DIV_W,
  parameter int IRQ_W = SSCM_IRQ_W
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // divider setting
  input  wire logic [DIV_W-1:0] div_value,
  // tx clocking setting
  input  wire logic [1:0]       tx_bit_clock_source_select,
  input  wire logic             tx_bit_clock_invert,
  input  wire logic [1:0]       tx_clock_pin_output_mode,
  input  wire logic [2:0]       tx_start_select,
  input  wire logic             tx_enable,
  // rx clocking setting
  input  wire logic [1:0]       rx_bit_clock_source_select,
  input  wire logic             rx_bit_clock_invert,
  input  wire logic [1:0]       rx_clock_pin_output_mode,
  input  wire logic [2:0]       rx_start_select,
  input  wire logic             rx_enable,
  // transfer activity from the shift logic
  input  wire logic             tx_data_ready,
  input  wire logic             tx_xfer_done,
  input  wire logic             rx_xfer_done,
  // tx pins
  input  wire logic             tx_clock_pin_in,
  output logic                  tx_clock_pin_out,
  output logic                  tx_clock_pin_oe_n,
  input  wire logic             tx_frame_sync_pin_in,
  output logic                  tx_frame_sync_pin_out,
  output logic                  tx_frame_sync_pin_oe_n,
  output logic                  tx_data_pin,
  input  wire logic             tx_data_bit,
  input  wire logic             tx_frame_sync_drive,
  input  wire logic             tx_frame_sync_level,
  // rx pins
  input  wire logic             rx_clock_pin_in,
  output logic                  rx_clock_pin_out,
  output logic                  rx_clock_pin_oe_n,
  input  wire logic             rx_frame_sync_pin_in,
  output logic                  rx_frame_sync_pin_out,
  output logic                  rx_frame_sync_pin_oe_n,
  input  wire logic             rx_data_pin,
  output logic                  rx_data_bit,
  input  wire logic             rx_frame_sync_drive,
  input  wire logic             rx_frame_sync_level,
  // internal bit clocks and events towards the shift logic
  output logic                  tx_bit_clk,
  output logic                  rx_bit_clk,
  output logic                  tx_shift_edge,
  output logic                  rx_sample_edge,
  output logic                  tx_active,
  output logic                  rx_active,
  // interrupt
  input  wire logic [IRQ_W-1:0] irq_pending,
  input  wire logic [IRQ_W-1:0] irq_mask,
  output logic [IRQ_W-1:0]      irq_status,
  output logic                  irq
);

  initial begin
    if (DIV_W != SSCM_DIV_W) $error("sscm_top: divider must be 12 bits");
    if (IRQ_W < 1) $error("sscm_top: IRQ_W must be at least 1");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic sel_clk(input logic [1:0] sel, input logic pin_v,
                                   input logic other_v, input logic div_v);
    case (sel)
      SSCM_CKS_OTHER: sel_clk = other_v;
      SSCM_CKS_PIN:   sel_clk = pin_v;
      default:        sel_clk = div_v;
    endcase
  endfunction

  function automatic logic start_hit(input logic [2:0] sel, input logic fs,
                                     input logic fs_prev, input logic other_go);
    case (sel)
      SSCM_START_AUTO:  start_hit = 1'b1;
      SSCM_START_OTHER: start_hit = other_go;
      SSCM_START_LOW:   start_hit = !fs;
      SSCM_START_HIGH:  start_hit = fs;
      SSCM_START_FALL:  start_hit = fs_prev && !fs;
      SSCM_START_RISE:  start_hit = !fs_prev && fs;
      SSCM_START_LEVEL: start_hit = fs != fs_prev;
      SSCM_START_EDGE:  start_hit = fs != fs_prev;
      default:          start_hit = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // divided clock
  // ---------------------------------------------------------------
  logic div_clk;
  logic div_rise;
  logic div_fall;

  sscm_divider #(
    .DIV_W (DIV_W)
  ) u_div (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .div_value (div_value),
    .div_clk   (div_clk),
    .div_rise  (div_rise),
    .div_fall  (div_fall)
  );

  // ---------------------------------------------------------------
  // clock source selection
  // ---------------------------------------------------------------
  logic tx_sel_clk;
  logic rx_sel_clk;
  logic tx_pin_reg;
  logic rx_pin_reg;
  logic tx_raw_rx;
  logic rx_raw_tx;

  // the cross paths use the other side's pin or divider, never a loop
  assign tx_raw_rx = (rx_bit_clock_source_select == SSCM_CKS_PIN) ? rx_clock_pin_in : div_clk;
  assign rx_raw_tx = (tx_bit_clock_source_select == SSCM_CKS_PIN) ? tx_clock_pin_in : div_clk;
  assign tx_sel_clk = sel_clk(tx_bit_clock_source_select, tx_clock_pin_in,
                              tx_raw_rx, div_clk);
  assign rx_sel_clk = sel_clk(rx_bit_clock_source_select, rx_clock_pin_in,
                              rx_raw_tx, div_clk);

  // ---------------------------------------------------------------
  // internal bit clocks with inversion
  // ---------------------------------------------------------------
  logic tx_int_reg;
  logic rx_int_reg;
  logic tx_int_next;
  logic rx_int_next;

  assign tx_int_next = tx_sel_clk ^ tx_bit_clock_invert;
  assign rx_int_next = rx_sel_clk ^ rx_bit_clock_invert;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_int_reg <= 1'b0;
      rx_int_reg <= 1'b0;
    end else begin
      tx_int_reg <= tx_int_next;
      rx_int_reg <= rx_int_next;
    end
  end

  assign tx_bit_clk     = tx_int_reg;
  assign rx_bit_clk     = rx_int_reg;
  // tx shifts on falling edge, rx samples on rising edge of internal clock
  assign tx_shift_edge  = tx_int_reg && !tx_int_next;
  assign rx_sample_edge = !rx_int_reg && rx_int_next;

  // ---------------------------------------------------------------
  // frame sync sampling
  // ---------------------------------------------------------------
  logic tx_fs_prev_reg;
  logic rx_fs_prev_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_fs_prev_reg <= 1'b0;
      rx_fs_prev_reg <= 1'b0;
    end else begin
      tx_fs_prev_reg <= tx_frame_sync_pin_in;
      rx_fs_prev_reg <= rx_frame_sync_pin_in;
    end
  end

  // ---------------------------------------------------------------
  // transfer start and activity
  // ---------------------------------------------------------------
  sscm_state_e tx_state_reg;
  sscm_state_e rx_state_reg;
  logic        tx_go;
  logic        rx_go;
  logic        tx_trig;
  logic        rx_trig;

  assign tx_trig = start_hit(tx_start_select, tx_frame_sync_pin_in, tx_fs_prev_reg,
                             rx_go) && (tx_start_select != SSCM_START_AUTO ||
                             tx_data_ready);
  assign rx_trig = start_hit(rx_start_select, rx_frame_sync_pin_in, rx_fs_prev_reg,
                             tx_go);
  assign tx_go = (tx_state_reg == SSCM_WAIT) && tx_trig;
  // tx follows an rx start on rx's own events only, keeping the start paths loop free
  assign rx_go = (rx_state_reg == SSCM_WAIT) &&
                 start_hit(rx_start_select, rx_frame_sync_pin_in, rx_fs_prev_reg, 1'b0);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_state_reg <= SSCM_IDLE;
    end else begin
      case (tx_state_reg)
        SSCM_IDLE: if (tx_enable) tx_state_reg <= SSCM_WAIT;
        SSCM_WAIT: begin
          if (!tx_enable) tx_state_reg <= SSCM_IDLE;
          else if (tx_trig) tx_state_reg <= SSCM_XFER;
        end
        SSCM_XFER: begin
          if (!tx_enable) tx_state_reg <= SSCM_IDLE;
          else if (tx_xfer_done) tx_state_reg <= SSCM_WAIT;
        end
        default: tx_state_reg <= SSCM_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_state_reg <= SSCM_IDLE;
    end else begin
      case (rx_state_reg)
        SSCM_IDLE: if (rx_enable) rx_state_reg <= SSCM_WAIT;
        SSCM_WAIT: begin
          if (!rx_enable) rx_state_reg <= SSCM_IDLE;
          else if (rx_trig) rx_state_reg <= SSCM_XFER;
        end
        SSCM_XFER: begin
          if (!rx_enable) rx_state_reg <= SSCM_IDLE;
          else if (rx_xfer_done) rx_state_reg <= SSCM_WAIT;
        end
        default: rx_state_reg <= SSCM_IDLE;
      endcase
    end
  end

  assign tx_active = (tx_state_reg == SSCM_XFER);
  assign rx_active = (rx_state_reg == SSCM_XFER);

  // ---------------------------------------------------------------
  // clock pin drive, taken before inversion
  // ---------------------------------------------------------------
  logic tx_drive;
  logic rx_drive;

  assign tx_drive = (tx_clock_pin_output_mode == SSCM_CKO_CONT) ||
                    (tx_clock_pin_output_mode == SSCM_CKO_XFER && tx_active);
  assign rx_drive = (rx_clock_pin_output_mode == SSCM_CKO_CONT) ||
                    (rx_clock_pin_output_mode == SSCM_CKO_XFER && rx_active);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_pin_reg <= 1'b0;
      rx_pin_reg <= 1'b0;
    end else begin
      tx_pin_reg <= tx_drive ? tx_sel_clk : 1'b0;
      rx_pin_reg <= rx_drive ? rx_sel_clk : 1'b0;
    end
  end

  assign tx_clock_pin_out  = tx_pin_reg;
  assign rx_clock_pin_out  = rx_pin_reg;
  assign tx_clock_pin_oe_n = !tx_drive;
  assign rx_clock_pin_oe_n = !rx_drive;

  // ---------------------------------------------------------------
  // frame sync and data pins
  // ---------------------------------------------------------------
  logic tx_fs_out_reg;
  logic rx_fs_out_reg;
  logic tx_data_reg;
  logic rx_data_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_fs_out_reg <= 1'b0;
      rx_fs_out_reg <= 1'b0;
      tx_data_reg   <= 1'b0;
      rx_data_reg   <= 1'b0;
    end else begin
      tx_fs_out_reg <= tx_frame_sync_level;
      rx_fs_out_reg <= rx_frame_sync_level;
      tx_data_reg   <= tx_data_bit;
      if (rx_sample_edge) rx_data_reg <= rx_data_pin;
    end
  end

  assign tx_frame_sync_pin_out  = tx_fs_out_reg;
  assign rx_frame_sync_pin_out  = rx_fs_out_reg;
  assign tx_frame_sync_pin_oe_n = !tx_frame_sync_drive;
  assign rx_frame_sync_pin_oe_n = !rx_frame_sync_drive;
  assign tx_data_pin            = tx_data_reg;
  assign rx_data_bit            = rx_data_reg;

  // ---------------------------------------------------------------
  // interrupt
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] irq_status_reg;
  logic             irq_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_status_reg <= '0;
      irq_reg        <= 1'b0;
    end else begin
      irq_status_reg <= irq_pending;
      irq_reg        <= |(irq_pending & irq_mask);
    end
  end

  assign irq_status = irq_status_reg;
  assign irq        = irq_reg;

endmodule

// *** test/sscm_top_properties.sv ***
// concurrent checks on the ports of the serial clock management block
`timescale 1ns/1ps
module sscm_top_checker
  import sscm_pkg::*;
#(
  parameter int DIV_W = SSCM_DIV_W,
  parameter int IRQ_W = SSCM_IRQ_W
) (
  // clock and reset
  input wire logic             core_clk,
  input wire logic             rst_n,
  // settings
  input wire logic [DIV_W-1:0] div_value,
  input wire logic [1:0]       tx_bit_clock_source_select,
  input wire logic             tx_bit_clock_invert,
  input wire logic [1:0]       tx_clock_pin_output_mode,
  input wire logic             rx_bit_clock_invert,
  input wire logic [1:0]       rx_clock_pin_output_mode,
  // clocks and pins
  input wire logic             tx_clock_pin_out,
  input wire logic             tx_clock_pin_oe_n,
  input wire logic             rx_clock_pin_out,
  input wire logic             rx_clock_pin_oe_n,
  input wire logic             tx_bit_clk,
  input wire logic             rx_bit_clk,
  input wire logic             rx_active,
  // interrupt
  input wire logic [IRQ_W-1:0] irq_pending,
  input wire logic [IRQ_W-1:0] irq_mask,
  input wire logic [IRQ_W-1:0] irq_status,
  input wire logic             irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // length of the current divided phase, toggles seen under one setting
  logic [DIV_W:0] len_reg;
  logic [1:0]     tog_reg;
  logic           div_sel;
  assign div_sel = (tx_bit_clock_source_select == SSCM_CKS_DIV) && (div_value != '0);
  always_ff @(posedge core_clk) begin
    if (!rst_n || !div_sel || $changed(div_value) || $changed(tx_bit_clock_invert)) begin
      len_reg <= '0;
      tog_reg <= 2'h0;
    end else if ($changed(tx_bit_clk)) begin
      len_reg <= (DIV_W+1)'(1);
      tog_reg <= (tog_reg == 2'h3) ? 2'h3 : tog_reg + 2'h1;
    end else begin
      len_reg <= len_reg + (DIV_W+1)'(1);
    end
  end

  property p_div_phase;
    div_sel && $stable(div_value) && $changed(tx_bit_clk) && tog_reg == 2'h3
      |-> len_reg == {1'b0, div_value};
  endproperty
  a_div_phase: assert property (p_div_phase) else $error("divided phase length wrong");
  property p_div_off;
    (div_value == '0 && tx_bit_clock_source_select == SSCM_CKS_DIV && !tx_bit_clock_invert)[*3]
      |=> !tx_bit_clk;
  endproperty
  a_div_off: assert property (p_div_off) else $error("divided clock runs at zero");
  property p_tx_inv;
    $past(rst_n) && $past(tx_clock_pin_output_mode) == SSCM_CKO_CONT
      |-> tx_bit_clk == (tx_clock_pin_out ^ $past(tx_bit_clock_invert));
  endproperty
  a_tx_inv: assert property (p_tx_inv) else $error("tx inversion wrong");
  property p_rx_inv;
    $past(rst_n) && $past(rx_clock_pin_output_mode) == SSCM_CKO_CONT
      |-> rx_bit_clk == (rx_clock_pin_out ^ $past(rx_bit_clock_invert));
  endproperty
  a_rx_inv: assert property (p_rx_inv) else $error("rx inversion wrong");
  property p_tx_cont;
    tx_clock_pin_output_mode == SSCM_CKO_CONT |-> !tx_clock_pin_oe_n;
  endproperty
  a_tx_cont: assert property (p_tx_cont) else $error("tx pin not driven");
  property p_rx_xfer;
    rx_clock_pin_output_mode == SSCM_CKO_XFER |-> rx_clock_pin_oe_n == !rx_active;
  endproperty
  a_rx_xfer: assert property (p_rx_xfer) else $error("rx pin drive off transfer");
  property p_irq;
    $past(rst_n) |-> irq == (|$past(irq_pending & irq_mask));
  endproperty
  a_irq: assert property (p_irq) else $error("irq not pending and mask");
  property p_status;
    $past(rst_n) |-> irq_status == $past(irq_pending);
  endproperty
  a_status: assert property (p_status) else $error("status not pending");
endmodule

bind sscm_top sscm_top_checker #(.DIV_W(DIV_W), .IRQ_W(IRQ_W)) chk_u (
  .core_clk, .rst_n, .div_value, .tx_bit_clock_source_select, .tx_bit_clock_invert,
  .tx_clock_pin_output_mode, .rx_bit_clock_invert, .rx_clock_pin_output_mode,
  .tx_clock_pin_out, .tx_clock_pin_oe_n, .rx_clock_pin_out, .rx_clock_pin_oe_n,
  .tx_bit_clk, .rx_bit_clk, .rx_active, .irq_pending, .irq_mask, .irq_status, .irq);

// *** test/sscm_codec_model.sv ***
// external codec model clocking the clock pins that the block leaves free
`timescale 1ns/1ps
module sscm_codec_model #(
  parameter int HALF = 3
) (
  // clock and control
  input  wire logic core_clk,
  input  wire logic run,
  // block side of the pins
  input  wire logic tx_clock_pin_out,
  input  wire logic tx_clock_pin_oe_n,
  input  wire logic rx_clock_pin_out,
  input  wire logic rx_clock_pin_oe_n,
  // resolved pin levels
  output logic      tx_clock_wire,
  output logic      rx_clock_wire,
  output logic      rx_data_wire
);
  // half period kept at three master clocks or more
  localparam int HOK = (HALF < 3) ? 3 : HALF;
  int         cnt = 0;
  logic       clk_q = 1'b0;
  logic [7:0] pat = 8'ha5;
  // clock stands still low outside a run
  always @(posedge core_clk) begin
    if (!run) begin
      cnt <= 0;
      clk_q <= 1'b0;
    end else if (cnt == HOK - 1) begin
      cnt <= 0;
      clk_q <= ~clk_q;
      pat <= {pat[6:0], pat[7]};
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign tx_clock_wire = tx_clock_pin_oe_n ? clk_q : tx_clock_pin_out;
  assign rx_clock_wire = rx_clock_pin_oe_n ? clk_q : rx_clock_pin_out;
  assign rx_data_wire  = run ? pat[7] : ~pat[7];
endmodule

// *** test/test_sscm_top.sv ***
// self-checking testbench of the serial clock management block
`timescale 1ns/1ps
module test_sscm_top
  import sscm_pkg::*;
;
  localparam int HALF = 3;
  logic        core_clk, rst_n, codec_run, fs_rx, mon;
  logic [11:0] div_value;
  logic [11:0] dv [4] = '{12'h001, 12'h002, 12'h003, 12'hfff};
  logic [1:0]  tx_bit_clock_source_select, rx_bit_clock_source_select, mon_sel;
  logic [1:0]  tx_clock_pin_output_mode, rx_clock_pin_output_mode;
  logic [2:0]  tx_start_select, rx_start_select;
  logic        tx_bit_clock_invert, rx_bit_clock_invert, tx_enable, rx_enable;
  logic        tx_data_ready, tx_xfer_done, rx_xfer_done, tx_data_bit;
  logic        tx_frame_sync_drive, tx_frame_sync_level, rx_frame_sync_drive;
  logic        rx_frame_sync_level, tx_clock_pin_in, tx_clock_pin_out, tx_clock_pin_oe_n;
  logic        tx_frame_sync_pin_in, tx_frame_sync_pin_out, tx_frame_sync_pin_oe_n;
  logic        rx_clock_pin_in, rx_clock_pin_out, rx_clock_pin_oe_n, rx_frame_sync_pin_in;
  logic        rx_frame_sync_pin_out, rx_frame_sync_pin_oe_n, rx_data_pin, rx_data_bit;
  logic        tx_data_pin, tx_bit_clk, rx_bit_clk, tx_shift_edge, rx_sample_edge;
  logic        tx_active, rx_active, irq;
  logic [3:0]  irq_pending, irq_mask, irq_status;
  int          failures, cmp_count, n, k;

  assign tx_frame_sync_pin_in = tx_frame_sync_pin_oe_n ? 1'b0 : tx_frame_sync_pin_out;
  assign rx_frame_sync_pin_in = rx_frame_sync_pin_oe_n ? fs_rx : rx_frame_sync_pin_out;
  assign mon = (mon_sel == 2'h0) ? tx_clock_pin_out :
               (mon_sel == 2'h1) ? rx_clock_pin_out : rx_bit_clk;

  sscm_codec_model #(.HALF(HALF)) codec_u (
    .core_clk, .run(codec_run), .tx_clock_pin_out, .tx_clock_pin_oe_n, .rx_clock_pin_out,
    .rx_clock_pin_oe_n, .tx_clock_wire(tx_clock_pin_in), .rx_clock_wire(rx_clock_pin_in),
    .rx_data_wire(rx_data_pin));

  sscm_top dut_u (
    .core_clk, .rst_n, .div_value, .tx_bit_clock_source_select, .tx_bit_clock_invert,
    .tx_clock_pin_output_mode, .tx_start_select, .tx_enable, .rx_bit_clock_source_select,
    .rx_bit_clock_invert, .rx_clock_pin_output_mode, .rx_start_select, .rx_enable,
    .tx_data_ready, .tx_xfer_done, .rx_xfer_done, .tx_clock_pin_in, .tx_clock_pin_out,
    .tx_clock_pin_oe_n, .tx_frame_sync_pin_in, .tx_frame_sync_pin_out,
    .tx_frame_sync_pin_oe_n, .tx_data_pin, .tx_data_bit, .tx_frame_sync_drive,
    .tx_frame_sync_level, .rx_clock_pin_in, .rx_clock_pin_out, .rx_clock_pin_oe_n,
    .rx_frame_sync_pin_in, .rx_frame_sync_pin_out, .rx_frame_sync_pin_oe_n, .rx_data_pin,
    .rx_data_bit, .rx_frame_sync_drive, .rx_frame_sync_level, .tx_bit_clk, .rx_bit_clk,
    .tx_shift_edge, .rx_sample_edge, .tx_active, .rx_active, .irq_pending, .irq_mask,
    .irq_status, .irq);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // length of the next complete high phase of the watched clock
  task automatic phase(output int len);
    int j;
    for (j = 0; j < 9000 && mon !== 1'b0; j++) tick();
    for (j = 0; j < 9000 && mon !== 1'b1; j++) tick();
    for (len = 0; len < 9000 && mon === 1'b1; len++) tick();
  endtask
  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge core_clk);
    failures++;
    wrap_up();
  end

  initial begin
    {failures, cmp_count, n, k} = '0;
    {rst_n, codec_run, fs_rx, mon_sel, div_value} = '0;
    {tx_bit_clock_source_select, rx_bit_clock_source_select} = '0;
    {tx_clock_pin_output_mode, rx_clock_pin_output_mode} = '0;
    {tx_start_select, rx_start_select, tx_bit_clock_invert, rx_bit_clock_invert} = '0;
    {tx_enable, rx_enable, tx_data_ready, tx_xfer_done, rx_xfer_done, tx_data_bit} = '0;
    {tx_frame_sync_drive, tx_frame_sync_level, rx_frame_sync_drive} = '0;
    {rx_frame_sync_level, irq_pending, irq_mask} = '0;
    repeat (16) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    tick();
    chk({tx_clock_pin_oe_n, rx_clock_pin_oe_n, irq}, 3'h6);
    {tx_data_bit, tx_frame_sync_drive, tx_frame_sync_level} = 3'h7;
    repeat (2) tick();
    chk({tx_data_pin, tx_frame_sync_pin_out, tx_frame_sync_pin_oe_n}, 3'h6);
    // divided clock on both sides, own pin never a source here
    tx_clock_pin_output_mode = SSCM_CKO_CONT;
    rx_clock_pin_output_mode = SSCM_CKO_CONT;
    for (int i = 0; i < 4; i++) begin
      div_value = dv[i];
      tx_bit_clock_source_select = (i == 1) ? 2'h3 : SSCM_CKS_DIV;
      repeat (2) tick();
      mon_sel = 2'h0;
      phase(n);
      chk(n, dv[i]);
      mon_sel = 2'h2;
      phase(n);
      chk(n, dv[i]);
    end
    div_value = 12'h000;
    repeat (4) tick();
    for (int i = 0; i < 12; i++) begin
      tick();
      chk({tx_clock_pin_out, tx_bit_clk}, 2'h0);
    end
    div_value = 12'h002;
    tx_bit_clock_invert = 1'b1;
    repeat (3) tick();
    for (int i = 0; i < 8; i++) begin
      tick();
      chk({tx_bit_clk, rx_bit_clk}, {~tx_clock_pin_out, rx_clock_pin_out});
    end
    tx_bit_clock_invert = 1'b0;
    // codec clock on one pin, passed across to the other side
    codec_run = 1'b1;
    tx_clock_pin_output_mode = SSCM_CKO_NONE;
    tx_bit_clock_source_select = SSCM_CKS_PIN;
    rx_bit_clock_source_select = SSCM_CKS_OTHER;
    mon_sel = 2'h1;
    phase(n);
    phase(n);
    chk(n, HALF);
    rx_clock_pin_output_mode = SSCM_CKO_NONE;
    rx_bit_clock_source_select = SSCM_CKS_PIN;
    tx_bit_clock_source_select = SSCM_CKS_OTHER;
    tx_clock_pin_output_mode = SSCM_CKO_CONT;
    mon_sel = 2'h0;
    phase(n);
    phase(n);
    chk(n, HALF);
    codec_run = 1'b0;
    // every rx start selection, pins driven only during transfers
    tx_bit_clock_source_select = SSCM_CKS_DIV;
    rx_bit_clock_source_select = SSCM_CKS_DIV;
    tx_clock_pin_output_mode = SSCM_CKO_XFER;
    rx_clock_pin_output_mode = SSCM_CKO_XFER;
    tx_enable = 1'b1;
    for (int c = 0; c < 8; c++) begin
      rx_start_select = c[2:0];
      fs_rx = (c == 2 || c == 4);
      tick();
      rx_enable = 1'b1;
      repeat (4) tick();
      chk({rx_active, rx_clock_pin_oe_n, tx_clock_pin_oe_n}, {c == 0, c != 0, 1'b1});
      if (c == 1) tx_data_ready = 1'b1;
      else fs_rx = ~fs_rx;
      for (k = 0; k < 20 && rx_active !== 1'b1; k++) tick();
      tick();
      chk({rx_active, rx_clock_pin_oe_n, tx_clock_pin_oe_n}, {2'h2, c != 1});
      {rx_xfer_done, tx_xfer_done, tx_data_ready} = 3'h6;
      tick();
      {rx_xfer_done, tx_xfer_done, rx_enable} = 3'h0;
      tick();
    end
    for (int i = 0; i < 16; i++) begin
      irq_pending = i[3:0];
      irq_mask = i[3:0] ^ 4'h3;
      repeat (2) tick();
      chk({irq, irq_status}, {|(i[3:0] & (i[3:0] ^ 4'h3)), i[3:0]});
    end
    chk(rx_data_bit, rx_data_pin);
    wrap_up();
  end
endmodule
